// *** pkg/fetch_core_regs.vh ***
// Constants for the two-stage fetch/execute sequencing core
`ifndef FETCH_CORE_REGS_VH
`define FETCH_CORE_REGS_VH

// Phase counter codes, one instruction cycle is four oscillator edges
`define PHASE_ONE_CODE     2'h0
`define PHASE_TWO_CODE     2'h1
`define PHASE_THREE_CODE   2'h2
`define PHASE_FOUR_CODE    2'h3

// Widths
`define INSTR_WIDTH        14
`define DATA_WIDTH         8
`define PC_WIDTH           13
`define DADDR_WIDTH        9

// Reset values
`define PC_RESET           13'h0000
`define NOP_WORD           14'h0000

// Instruction class decode (top bits of the word, or the whole word)
`define OPC_TOP_JUMP       3'h5
`define OPC_TOP_CALL       3'h4
`define OPC_TOP_FILE       2'h0
`define OPC_SLEEP          14'h0063
`define OPC_WDT_CLEAR      14'h0064
`define OPC_RETURN         14'h0008

// Special register address of the program counter low byte
`define PCL_ADDR           7'h02
// Indirect-address marker and pointer register address
`define INDF_ADDR          7'h00
`define FSR_ADDR           7'h04

`endif

// *** hw/fetch_execute_core.v ***
// Two-stage fetch/execute sequencing core with phase generator
// Behaviour
// RULE_01 - Divide oscillator by four into four non-overlapping phase strobes.
// RULE_02 - Program counter increments in phase one, starting next fetch.
// RULE_03 - Fetched word captured into holding register in phase four.
// RULE_04 - Held instruction decoded and executed in phases two to four.
// RULE_05 - Data operand read in phase two, result written in phase four.
// RULE_06 - Fetch overlaps execute; one instruction completes per cycle.
// RULE_07 - Each instruction is one 14-bit word fetched in one cycle.
// RULE_08 - Data path is 8 bits, separate from the instruction path.
// RULE_09 - Data memory accessed on own bus while program fetch proceeds.
// RULE_10 - Program-counter-changing instructions take two instruction cycles.
// RULE_11 - Word fetched behind a branch is flushed and runs as no-op.
// RULE_12 - Call pushes return address on stack, then loads target.
// RULE_13 - After flush, target executes while target plus one is fetched.
// RULE_14 - Special registers incl. program counter mapped in data space. The counter is write-only here; reads of its address return data memory.
// RULE_15 - Sleep instruction places device into lowest power mode.
// RULE_16 - Watchdog clear instruction restarts the watchdog counter.
// RULE_17 - After reset the first execute cycle is a no-op.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_core_regs.vh"

module fetch_execute_core #(
  parameter STACK_DEPTH = 8,
  parameter STACK_AW    = 3
) (
  // Clock and reset
  input  wire                        sys_clk_in,
  input  wire                        sys_rst_in,
  // Program memory bus
  input  wire [`INSTR_WIDTH-1:0]     prog_data_in,
  output reg  [`PC_WIDTH-1:0]        prog_addr_out,
  // Data memory bus
  input  wire [`DATA_WIDTH-1:0]      data_rd_in,
  output reg  [`DADDR_WIDTH-1:0]     data_addr_out,
  output reg                         data_rd_en_out,
  output reg  [`DATA_WIDTH-1:0]      data_wr_out,
  output reg                         data_wr_en_out,
  // Phase strobes
  output reg                         phase_one_out,
  output reg                         phase_two_out,
  output reg                         phase_three_out,
  output reg                         phase_four_out,
  // Power and watchdog control
  input  wire                        wake_in,
  output reg                         sleep_out,
  output reg                         watchdog_clear_out,
  output reg                         flush_out
);

  // Phase state, codes are the phase numbers minus one
  localparam [1:0] PH1 = `PHASE_ONE_CODE;
  localparam [1:0] PH2 = `PHASE_TWO_CODE;
  localparam [1:0] PH3 = `PHASE_THREE_CODE;
  localparam [1:0] PH4 = `PHASE_FOUR_CODE;

  reg  [1:0]               phase_q;
  reg  [`PC_WIDTH-1:0]     pc_q;
  reg  [`INSTR_WIDTH-1:0]  instruction_holding_register_q;
  reg                      flush_q;
  reg                      exec_valid_q;
  reg  [`DATA_WIDTH-1:0]   wreg_q;
  reg  [`DATA_WIDTH-1:0]   operand_q;
  reg  [`DATA_WIDTH-1:0]   fsr_q;
  reg                      sleep_q;
  reg  [`PC_WIDTH-1:0]     stack_q [0:STACK_DEPTH-1];
  reg  [STACK_AW-1:0]      sp_q;
  reg  [1:0]               wake_sync_q;
  integer                  i;

  // Timing of one instruction cycle, counted in oscillator edges.
  // Edge names below use the phase held just before the edge.
  //
  // Edge in phase one:
  //   Counter steps forward by one.
  //   Fetch address latched from the old count, so the word
  //   fetched is the one the counter pointed at, not the next.
  //   Phase one strobe rises on this edge, one edge late.
  //
  // Edge in phase two:
  //   Operand address and read strobe launched for file ops.
  //   Read strobe therefore stands during phase three.
  //
  // Edge in phase three:
  //   Operand byte taken from the data bus.
  //   Memory must answer combinationally within that cycle.
  //
  // Edge in phase four:
  //   Result or moved byte launched with the write strobe.
  //   Write strobe therefore stands during the next phase one.
  //   Fetched word taken into the holding register.
  //   Branch, call and return retire and set the flush flag.
  //
  // Fetch address stands for the whole instruction cycle,
  // giving program memory three edges to settle its word.
  //
  // Flush handling:
  //   The word behind a branch is loaded as usual, then
  //   ignored by the decode through the run qualifier.
  //   Flushed cycles never touch data memory and never
  //   raise the sleep or watchdog clear strobes.
  //
  // Call handling:
  //   The fetch address at retirement is the word right
  //   after the call, which is exactly the return address.
  //   Using the counter instead would skip one word.
  //
  // Stack limitation:
  //   No overflow or underflow detection; the pointer wraps
  //   silently, as on the original style of core.
  //   Software must keep nesting within the stack depth.
  //
  // Sleep handling:
  //   All phase logic freezes, strobes drop, the fetch
  //   address holds. Only the wake synchroniser keeps
  //   running, since it is the sole way back out.
  //   A word captured on the sleep edge runs after wake.
  //
  // Reset handling:
  //   Holding register is a no-op and the run qualifier is
  //   low, so the first execute cycle does nothing while
  //   the word at address zero is fetched.
  //
  // Indirect access:
  //   File address zero reads through the pointer register.
  //   The pointer is updated when written as a destination.
  //
  // Trade-off:
  //   Outputs are registered, so every strobe appears one
  //   edge after the phase that launches it; the far side
  //   sees clean levels at the cost of that edge.

  // Address of the file operand: direct, or indirect through the pointer register at address zero
  function [`DADDR_WIDTH-1:0] file_addr;
    input [`INSTR_WIDTH-1:0] w;
    input [`DATA_WIDTH-1:0]  ptr;
    begin
      if (w[6:0] == `INDF_ADDR) begin
        file_addr = {1'b0, ptr};
      end else begin
        file_addr = {2'b00, w[6:0]};
      end
    end
  endfunction

  wire [`INSTR_WIDTH-1:0] ir = instruction_holding_register_q;
  wire run = exec_valid_q & ~flush_q;
  wire is_jump = run & (ir[13:11] == `OPC_TOP_JUMP);
  wire is_call = run & (ir[13:11] == `OPC_TOP_CALL);
  wire is_ret  = run & (ir == `OPC_RETURN);
  wire is_file = run & (ir[13:12] == `OPC_TOP_FILE) & (ir[11:8] != 4'h0);
  wire is_mov  = run & (ir[13:7] == 7'h01);
  wire is_sleep = run & (ir == `OPC_SLEEP);
  wire is_wdt   = run & (ir == `OPC_WDT_CLEAR);
  // Writing the program counter low byte is a branch as well
  wire pcl_dest = (is_file & ir[7] | is_mov) & (ir[6:0] == `PCL_ADDR);
  wire branch = is_jump | is_call | is_ret | pcl_dest;
  wire [`DADDR_WIDTH-1:0] daddr = file_addr(ir, fsr_q);

  // Result of a file operation, small subset of the datapath
  reg [`DATA_WIDTH-1:0] result;
  always @* begin
    case (ir[11:8])
      4'h7:    result = operand_q + wreg_q;
      4'h5:    result = operand_q & wreg_q;
      4'h4:    result = operand_q | wreg_q;
      4'h6:    result = operand_q ^ wreg_q;
      4'hA:    result = operand_q + 8'h01;
      4'h3:    result = operand_q - 8'h01;
      default: result = operand_q;
    endcase
  end

  // Wake pin is asynchronous, two flops before use
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_sync_q <= 2'h0;
    end else begin
      wake_sync_q <= {wake_sync_q[0], wake_in};
    end
  end

  // RULE_01 phase divider
  // Phases stop while asleep: that is the low power state
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_q <= PH1;
    end else if (!sleep_q) begin
      case (phase_q)
        PH1:     phase_q <= PH2;
        PH2:     phase_q <= PH3;
        PH3:     phase_q <= PH4;
        default: phase_q <= PH1;
      endcase
    end
  end

  // Registered phase strobes, never overlapping, one-hot except all low in reset and sleep
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_one_out   <= 1'b0;
      phase_two_out   <= 1'b0;
      phase_three_out <= 1'b0;
      phase_four_out  <= 1'b0;
    end else begin
      phase_one_out   <= ~sleep_q & (phase_q == PH1);
      phase_two_out   <= ~sleep_q & (phase_q == PH2);
      phase_three_out <= ~sleep_q & (phase_q == PH3);
      phase_four_out  <= ~sleep_q & (phase_q == PH4);
    end
  end

  // Program counter, stack and flush control
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_q    <= `PC_RESET;
      sp_q    <= {STACK_AW{1'b0}};
      flush_q <= 1'b0;
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stack_q[i] <= `PC_RESET;
      end
    end else if (!sleep_q) begin
      // RULE_02 increment in phase one
      if (phase_q == PH1) begin
        pc_q <= pc_q + 1'b1;
      end
      // RULE_10 branch retires in phase four
      if (phase_q == PH4) begin
        // RULE_11 flag next executed word as no-op
        flush_q <= branch;
        if (is_call) begin
          // RULE_12 push follow-on address, then load target
          stack_q[sp_q] <= prog_addr_out;
          sp_q          <= sp_q + 1'b1;
          pc_q          <= {pc_q[12:11], ir[10:0]};
        end else if (is_jump) begin
          pc_q <= {pc_q[12:11], ir[10:0]};
        end else if (is_ret) begin
          pc_q <= stack_q[sp_q - 1'b1];
          sp_q <= sp_q - 1'b1;
        end else if (pcl_dest) begin
          // RULE_14 program counter reachable as data
          pc_q <= {pc_q[12:8], result};
        end
      end
    end
  end

  // RULE_07 whole 14-bit word fetched
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      instruction_holding_register_q <= `NOP_WORD;
      exec_valid_q                   <= 1'b0;
      prog_addr_out                  <= `PC_RESET;
    end else if (!sleep_q) begin
      // Fetch address taken before the increment lands
      if (phase_q == PH1) begin
        prog_addr_out <= pc_q;
      end
      // RULE_03 capture in phase four
      // RULE_06 this fetch overlaps current execute
      if (phase_q == PH4) begin
        instruction_holding_register_q <= prog_data_in;
        // RULE_17 first cycle after reset executes nothing
        exec_valid_q <= 1'b1;
      end
    end
  end

  // RULE_04 execute phases two to four
  // RULE_05 operand read phase two, write phase four
  // RULE_09 data bus runs beside program fetch
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_addr_out  <= {`DADDR_WIDTH{1'b0}};
      data_rd_en_out <= 1'b0;
      data_wr_en_out <= 1'b0;
      data_wr_out    <= {`DATA_WIDTH{1'b0}};
      operand_q      <= {`DATA_WIDTH{1'b0}};
      wreg_q         <= {`DATA_WIDTH{1'b0}};
      fsr_q          <= {`DATA_WIDTH{1'b0}};
    end else begin
      data_rd_en_out <= 1'b0;
      data_wr_en_out <= 1'b0;
      if (!sleep_q) begin
        case (phase_q)
          PH2: begin
            // RULE_08 8-bit operand bus
            // RULE_14 direct or indirect address
            if (is_file) begin
              data_addr_out  <= daddr;
              data_rd_en_out <= 1'b1;
            end
          end
          PH3: begin
            operand_q <= data_rd_in;
          end
          PH4: begin
            if (is_mov) begin
              data_addr_out  <= daddr;
              data_wr_out    <= wreg_q;
              data_wr_en_out <= 1'b1;
              if (ir[6:0] == `FSR_ADDR) begin
                fsr_q <= wreg_q;
              end
            end else if (is_file & ir[7]) begin
              data_addr_out  <= daddr;
              data_wr_out    <= result;
              data_wr_en_out <= 1'b1;
              if (ir[6:0] == `FSR_ADDR) begin
                fsr_q <= result;
              end
            end else if (is_file) begin
              wreg_q <= result;
            end
          end
          default: begin
            data_rd_en_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // RULE_15 sleep and RULE_16 watchdog clear strobes
  // Wake acts only while asleep; a wake pulse that ends before the sleep set is lost
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sleep_q            <= 1'b0;
      sleep_out          <= 1'b0;
      watchdog_clear_out <= 1'b0;
      flush_out          <= 1'b0;
    end else begin
      watchdog_clear_out <= ~sleep_q & is_wdt & (phase_q == PH4);
      flush_out          <= ~sleep_q & flush_q & exec_valid_q;
      if (sleep_q & wake_sync_q[1]) begin
        sleep_q   <= 1'b0;
        sleep_out <= 1'b0;
      end else if (~sleep_q & is_sleep & (phase_q == PH4)) begin
        sleep_q   <= 1'b1;
        sleep_out <= 1'b1;
      end
    end
  end

endmodule // fetch_execute_core
`default_nettype wire

// *** sim/core_mem_model.sv ***
// Program and data memory model facing the sequencing core
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Program side
  input  wire logic [12:0] prog_addr_in,
  output wire logic [13:0] prog_data_out,
  // Data side
  input  wire logic [8:0]  data_addr_in,
  input  wire logic        data_rd_en_in,
  input  wire logic [7:0]  data_wr_in,
  input  wire logic        data_wr_en_in,
  output wire logic [7:0]  data_rd_out
);
  logic [13:0] rom [0:8191];
  logic [7:0]  ram [0:511];
  assign prog_data_out = rom[prog_addr_in];
  // own bus; inverted when idle so stale data is never seen
  assign data_rd_out = data_rd_en_in ? ram[data_addr_in] : ~ram[data_addr_in];
  always @(posedge sys_clk_in) begin
    if (data_wr_en_in) begin
      ram[data_addr_in] <= data_wr_in;
    end
  end
endmodule // core_mem_model
`default_nettype wire

// *** sim/core_chk_assertions.sv ***
// Port timing checker for the sequencing core
`timescale 1ns/1ps
`default_nettype none
module core_chk (
  // Clock and reset
  input wire sys_clk_in,
  input wire sys_rst_in,
  // Observed outputs
  input wire data_rd_en_out,
  input wire data_wr_en_out,
  input wire phase_one_out,
  input wire phase_two_out,
  input wire phase_three_out,
  input wire phase_four_out,
  input wire sleep_out,
  input wire watchdog_clear_out,
  input wire flush_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_PH12: assert property (phase_one_out |=> phase_two_out || sleep_out)
    else $error("phase two did not follow phase one");
  AST_PH41: assert property (phase_four_out |=> phase_one_out || sleep_out)
    else $error("phase one did not follow phase four");
  AST_ONEHOT: assert property ($onehot0({phase_one_out, phase_two_out,
    phase_three_out, phase_four_out})) else $error("phases overlap");
  AST_RD_PH: assert property (data_rd_en_out |-> phase_two_out
    ##1 !data_rd_en_out) else $error("read strobe out of place");
  AST_WR_PH: assert property (data_wr_en_out |-> phase_four_out
    ##1 !data_wr_en_out) else $error("write strobe out of place");
  AST_WD: assert property ($rose(watchdog_clear_out) |=> !watchdog_clear_out)
    else $error("watchdog clear not a pulse");
  AST_SLEEP: assert property (sleep_out && $past(sleep_out) |->
    !data_rd_en_out && !data_wr_en_out) else $error("strobe while asleep");
  AST_FLUSH: assert property (flush_out |-> !data_rd_en_out)
    else $error("read in flushed cycle");
endmodule // core_chk
bind fetch_execute_core core_chk core_chk_i (.sys_clk_in(sys_clk_in),
  .sys_rst_in(sys_rst_in), .data_rd_en_out(data_rd_en_out),
  .data_wr_en_out(data_wr_en_out), .phase_one_out(phase_one_out),
  .phase_two_out(phase_two_out), .phase_three_out(phase_three_out),
  .phase_four_out(phase_four_out), .sleep_out(sleep_out),
  .watchdog_clear_out(watchdog_clear_out), .flush_out(flush_out));
`default_nettype wire

// *** sim/fetch_execute_core_tb.sv ***
// Self-checking bench for the sequencing core
`timescale 1ns/1ps
`default_nettype none
`include "fetch_core_regs.vh"
module fetch_execute_core_tb;
  logic        sys_clk_in, sys_rst_in, wake_in;
  wire  [13:0] pdata;
  wire  [12:0] paddr;
  wire  [7:0]  rdata, wdata;
  wire  [8:0]  daddr;
  wire         rd_en, wr_en, ph1, ph2, ph3, ph4, slp, wd, fl;
  integer      n_mismatch, checks_done, nwr, nwd, nfl, n;
  logic [12:0] q [$];
  logic [8:0]  wa;
  fetch_execute_core fetch_execute_core_i (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .prog_data_in(pdata), .prog_addr_out(paddr),
    .data_rd_in(rdata), .data_addr_out(daddr), .data_rd_en_out(rd_en),
    .data_wr_out(wdata), .data_wr_en_out(wr_en), .phase_one_out(ph1),
    .phase_two_out(ph2), .phase_three_out(ph3), .phase_four_out(ph4),
    .wake_in(wake_in), .sleep_out(slp), .watchdog_clear_out(wd),
    .flush_out(fl));
  core_mem_model core_mem_model_i (.sys_clk_in(sys_clk_in),
    .prog_addr_in(paddr), .prog_data_out(pdata), .data_addr_in(daddr),
    .data_rd_en_in(rd_en), .data_wr_in(wdata), .data_wr_en_in(wr_en),
    .data_rd_out(rdata));
  // Clock at 100 MHz
  initial begin
    sys_clk_in = 0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Log fetch address where the word is taken, plus strobes
  always @(posedge sys_clk_in) begin
    #1;
    if (!sys_rst_in) begin
      if (ph3) q.push_back(paddr);
      if (wr_en === 1'b1) begin
        nwr++;
        wa = daddr;
      end
      if (wd === 1'b1) nwd++;
      if (fl === 1'b1 && ph4 && q.size() > 1) nfl++;
    end
  end
  task automatic chk(input string what, input [15:0] exp, input [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic run(input integer c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask
  // Load three words, clear logs, reset for 3 clocks
  task automatic start(input [13:0] w0, input [13:0] w1, input [13:0] w2);
    for (int i = 0; i < 8192; i++) core_mem_model_i.rom[i] = `NOP_WORD;
    core_mem_model_i.rom[0] = w0;
    core_mem_model_i.rom[1] = w1;
    core_mem_model_i.rom[2] = w2;
    sys_rst_in = 1;
    q.delete();
    nwr = 0; nwd = 0; nfl = 0;
    run(3);
    sys_rst_in = 0;
  endtask
  task automatic t_seq;
    start(`NOP_WORD, `NOP_WORD, `NOP_WORD);
    run(24);
    chk("fetch0", 0, q[0]);
    chk("fetch1", 1, q[1]);
    chk("fetch2", 2, q[2]);
    chk("writes", 0, nwr);
    chk("flushes", 0, nfl);
    $display("done t_seq");
  endtask
  task automatic t_jump;
    start(`NOP_WORD, 14'h280A, `NOP_WORD);
    run(32);
    chk("behind", 2, q[2]);
    chk("target", 10, q[3]);
    chk("next", 11, q[4]);
    chk("flushes", 1, nfl);
    $display("done t_jump");
  endtask
  task automatic t_call;
    start(`NOP_WORD, 14'h2014, `NOP_WORD);
    core_mem_model_i.rom[20] = `OPC_RETURN;
    run(40);
    chk("sub", 20, q[3]);
    chk("ret", 2, q[5]);
    chk("ret1", 3, q[6]);
    $display("done t_call");
  endtask
  task automatic t_ops;
    start(14'h00A5, `OPC_WDT_CLEAR, 14'h0825);
    run(28);
    chk("nwr", 1, nwr);
    chk("waddr", 9'h025, wa);
    chk("wdclr", 1, nwd);
    chk("seq", 3, q[3]);
    $display("done t_ops");
  endtask
  task automatic t_sleep;
    start(`OPC_SLEEP, `NOP_WORD, `NOP_WORD);
    run(24);
    chk("asleep", 1, slp);
    n = q.size();
    run(16);
    chk("halted", n, q.size());
    wake_in = 1;
    run(8);
    wake_in = 0;
    run(16);
    chk("awake", 0, slp);
    chk("resumed", 1, q.size() > n);
    $display("done t_sleep");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, about ten times the expected run
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
  // Main sequence, inputs driven 1 ns after the edge
  initial begin
    n_mismatch = 0; checks_done = 0;
    sys_rst_in = 1; wake_in = 0;
    @(posedge sys_clk_in);
    #1;
    t_seq();
    t_jump();
    t_call();
    t_ops();
    t_sleep();
    close_out();
  end
endmodule // fetch_execute_core_tb
`default_nettype wire
